// >>> src/qdl_pin_sync.sv
/*
 * qdl_pin_sync: two-stage synchroniser and edge finder for the port pins.
 * Assumes: pins are asynchronous to ref_clk_i and far slower than it.
 */
`timescale 1ns/100ps
`default_nettype none
module qdl_pin_sync
   import qdl_pkg::*;
#(
   parameter int                N         = PIN_COUNT,
   parameter logic [N-1:0]      IDLE_LVL  = PIN_RESET
) (
   // clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         reset_i,
   // raw pins
   input  wire logic [N-1:0] pins_i,
   // synchronised bundle
   qdl_pins_if.src           sync_o
);
   typedef struct packed {
      logic [N-1:0] meta;  // first stage, read only by second stage
      logic [N-1:0] stab;
      logic [N-1:0] prev;
   } qdl_sync_t;

   qdl_sync_t state_reg;
   qdl_sync_t state_next;

   ////////////////////////////////////////////////////////////////////////////
   // next state: shift through the stages
   always_comb begin
      state_next      = state_reg;
      state_next.meta = pins_i;
      state_next.stab = state_reg.meta;
      state_next.prev = state_reg.stab;
   end

   // idle levels at reset avoid a false select edge after release
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= '{meta: IDLE_LVL, stab: IDLE_LVL, prev: IDLE_LVL};
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edges compare the stable stage with its own delayed copy
   assign sync_o.lvl  = state_reg.stab;
   assign sync_o.rise = state_reg.stab & ~state_reg.prev;
   assign sync_o.fall = ~state_reg.stab & state_reg.prev;
endmodule
`default_nettype wire

// >>> src/qdl_pins_if.sv
/*
 * qdl_pins_if: synchronised pin levels and their edge pulses.
 * Assumes: driver and reader share one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface qdl_pins_if #(parameter int N = 4);
   logic [N-1:0] lvl;   // synchronised level
   logic [N-1:0] rise;  // one-cycle pulse on rising edge
   logic [N-1:0] fall;  // one-cycle pulse on falling edge
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// >>> src/qdl_pkg.sv
/*
 * qdl_pkg: constants shared by the quad converter serial load port.
 * Assumes: a single 250 MHz reference clock samples every pin.
 */
package qdl_pkg;
   // frame layout, most significant bit first
   localparam int FRAME_BITS   = 16;
   localparam int VALUE_BITS   = 12;
   localparam int CHANNELS     = 4;
   localparam int ADDR_MSB     = 15;
   localparam int ADDR_LSB     = 14;
   localparam int CMD_MSB      = 13;
   localparam int CMD_LSB      = 12;
   localparam int VALUE_MSB    = 11;
   localparam int VALUE_LSB    = 0;

   // command_bits encodings
   localparam logic [1:0] CMD_LOAD_INPUT = 2'h0;  // input register only
   localparam logic [1:0] CMD_LOAD_BOTH  = 2'h1;  // input and converter register
   localparam logic [1:0] CMD_UPDATE_ALL = 2'h2;  // all converter regs from inputs
   localparam logic [1:0] CMD_OUT_EDGE   = 2'h3;  // address bit 1 picks output edge

   // pin bundle positions on the synchroniser
   localparam int PIN_COUNT    = 4;
   localparam int PIN_SCLK     = 0;
   localparam int PIN_SEL_N    = 1;
   localparam int PIN_SIN      = 2;
   localparam int PIN_LOAD_N   = 3;

   // reset values
   localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
   localparam logic [VALUE_BITS-1:0] VALUE_RESET = 12'h000;
   localparam logic                  SOUT_IDLE   = 1'b1;
   localparam logic                  EDGE_RESET  = 1'b0;  // falling-edge output
   localparam logic [PIN_COUNT-1:0]  PIN_RESET   = 4'hA;  // selects and strobe idle high
endpackage

// >>> src/qdl_serial_port.sv
/*
 * qdl_serial_port: serial load port of a four-channel 12-bit converter.
 * Assumes: shift clock, select, serial input and load strobe are pins from
 * an external master; ref_clk_i oversamples them (link period >= 80 ns).
 */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] each rising shift clock edge with select low shifts serial_in into the 16-bit register.
// [R2] shifting and the serial output are enabled only while select is low.
// [R3] the select rising edge commits the frame to the registers it addresses.
// [R4] a low load strobe copies every input register into its converter register.
// [R5] serial_out presents the bit leaving the far end of the shift register.
// [R6] with select high serial_out is held high.
// [R7] in falling-edge setting serial_out advances on each falling shift clock edge.
// [R8] in rising-edge setting serial_out advances on each rising shift clock edge.
// [R9] a frame is two address bits, two command bits, then a 12-bit value, msb first.
// [R10] the master sends 16 bits msb first and holds select low until all are shifted.
// [R11] the address and command code also picks the serial output edge.
// [R12] with the load strobe held low converter registers are transparent.
// [R13] with select high shift clock edges are ignored and all registers hold unless the load strobe is low.
module qdl_serial_port
   import qdl_pkg::*;
(
   // clock and reset
   input  wire logic                                ref_clk_i,
   input  wire logic                                reset_i,
   // serial link pins
   input  wire logic                                shift_clk_i,
   input  wire logic                                select_n_i,
   input  wire logic                                serial_in_i,
   input  wire logic                                load_all_strobe_n_i,
   output logic                                     serial_out_o,
   // converter register contents, channel 0 in the low bits
   output logic [CHANNELS-1:0][VALUE_BITS-1:0]      converter_value_o,
   output logic                                     out_on_rise_o
);
   typedef struct packed {
      logic [FRAME_BITS-1:0]                 shift;
      logic                                  sout;
      logic                                  out_on_rise;
      logic [CHANNELS-1:0][VALUE_BITS-1:0]   input_val;
      logic [CHANNELS-1:0][VALUE_BITS-1:0]   conv_val;
   } qdl_state_t;

   qdl_state_t state_reg;
   qdl_state_t state_next;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation, two flops before any logic
   qdl_pins_if #(.N(PIN_COUNT)) pins ();

   qdl_pin_sync #(
      .N        (PIN_COUNT),
      .IDLE_LVL (PIN_RESET)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .pins_i    ({load_all_strobe_n_i, serial_in_i, select_n_i, shift_clk_i}),
      .sync_o    (pins)
   );

   logic       sel_low;
   logic       sel_rise;
   logic       sel_fall;
   logic       sck_rise;
   logic       sck_fall;
   logic       sin;
   logic       load_low;
   logic [1:0] f_addr;
   logic [1:0] f_cmd;
   logic [VALUE_BITS-1:0] f_val;

   assign sel_low  = ~pins.lvl[PIN_SEL_N];
   assign sel_rise = pins.rise[PIN_SEL_N];
   assign sel_fall = pins.fall[PIN_SEL_N];
   assign sck_rise = pins.rise[PIN_SCLK];
   assign sck_fall = pins.fall[PIN_SCLK];
   assign sin      = pins.lvl[PIN_SIN];
   assign load_low = ~pins.lvl[PIN_LOAD_N];

   // [R9] frame field split
   assign f_addr = state_reg.shift[ADDR_MSB:ADDR_LSB];
   assign f_cmd  = state_reg.shift[CMD_MSB:CMD_LSB];
   assign f_val  = state_reg.shift[VALUE_MSB:VALUE_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_next = state_reg;
      if (sel_low) begin
         // [R1] shift on rising edge
         if (sck_rise) begin
            state_next.shift = {state_reg.shift[FRAME_BITS-2:0], sin};
            // [R8] rising-edge output advance
            if (state_reg.out_on_rise) begin
               state_next.sout = state_reg.shift[FRAME_BITS-2];
            end
         end
         // [R7] falling-edge output advance
         if (sck_fall && !state_reg.out_on_rise) begin
            state_next.sout = state_reg.shift[FRAME_BITS-1];
         end
         // [R5] far end shown as soon as select enables the output
         if (sel_fall) begin
            state_next.sout = state_reg.shift[FRAME_BITS-1];
         end
      end else begin
         // [R2] [R6] output disabled and held high
         state_next.sout = SOUT_IDLE;
      end
      // [R3] commit on select rising edge; [R13] otherwise registers hold
      if (sel_rise) begin
         case (f_cmd)
            CMD_LOAD_INPUT: begin
               state_next.input_val[f_addr] = f_val;
            end
            CMD_LOAD_BOTH: begin
               state_next.input_val[f_addr] = f_val;
               state_next.conv_val[f_addr]  = f_val;
            end
            CMD_UPDATE_ALL: begin
               state_next.conv_val = state_reg.input_val;
            end
            default: begin
               // [R11] edge setting from the address field
               state_next.out_on_rise = f_addr[1];
            end
         endcase
      end
      // [R4] [R12] strobe low copies all; placed last so a commit passes through
      if (load_low) begin
         state_next.conv_val = state_next.input_val;
      end
   end

   // registered state, reset to idle values
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= '{shift:       SHIFT_RESET,
                        sout:        SOUT_IDLE,
                        out_on_rise: EDGE_RESET,
                        input_val:   {CHANNELS{VALUE_RESET}},
                        conv_val:    {CHANNELS{VALUE_RESET}}};
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign serial_out_o      = state_reg.sout;
   assign converter_value_o = state_reg.conv_val;
   assign out_on_rise_o     = state_reg.out_on_rise;
endmodule
`default_nettype wire

// >>> test/qdl_link_master.sv
/* qdl_link_master: serial master model, 80 ns bit period.
   Assumes the caller waits for reset release first. */
`timescale 1ns/100ps
`default_nettype none
module qdl_link_master (
   // clock and echo
   input  wire logic ref_clk_i,
   input  wire logic serial_out_i,
   // link pins
   output logic      shift_clk_o,
   output logic      select_n_o,
   output logic      serial_in_o
);
   initial begin
      shift_clk_o = 1'b0;
      select_n_o = 1'b1;
      serial_in_o = 1'b0;
   end
   // half bit: 10 ref clocks, moved just after the edge
   task automatic half();
      repeat (10) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic xfer(input logic [15:0] w, input int gap, output logic [15:0] echo);
      select_n_o = 1'b0;
      half();
      for (int i = 15; i >= 0; i--) begin
         serial_in_o = w[i];
         half();
         echo[i] = serial_out_i; // sampled just before the rise in both modes
         shift_clk_o = 1'b1;
         half();
         shift_clk_o = 1'b0;
         if (i == 8) repeat (gap) half();
      end
      half();
      select_n_o = 1'b1;
      serial_in_o = ~serial_in_o; // released line shows no stale value
      half();
   endtask
   // clock edges with select high, deliberately outside a frame
   task automatic stray(input int n);
      repeat (n) begin
         shift_clk_o = 1'b1;
         serial_in_o = ~serial_in_o;
         half();
         shift_clk_o = 1'b0;
         half();
      end
   endtask
endmodule
`default_nettype wire

// >>> test/qdl_serial_port_monitor.sv
/* qdl_serial_port_monitor: pin-level timing checks on the serial load port.
   Assumes link half periods of at least 10 ref clocks. */
`timescale 1ns/100ps
`default_nettype none
module qdl_serial_port_monitor
   import qdl_pkg::*;
(
   // watched ports
   input wire logic                                 ref_clk_i,
   input wire logic                                 reset_i,
   input wire logic                                 shift_clk_i,
   input wire logic                                 select_n_i,
   input wire logic                                 load_all_strobe_n_i,
   input wire logic                                 serial_out_o,
   input wire logic [CHANNELS-1:0][VALUE_BITS-1:0]  converter_value_o,
   input wire logic                                 out_on_rise_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // windows exceed the 3-clock sync latency so late edges still settle
   chk_reset_state: assert property ($past(reset_i) |-> serial_out_o && !out_on_rise_o
      && converter_value_o == '0) else $error("bad state after reset");
   chk_idle_high: assert property (select_n_i [*6] |-> serial_out_o)
      else $error("serial out not high");
   chk_hold_regs: assert property ((select_n_i && load_all_strobe_n_i) [*7]
      |-> $stable(converter_value_o)) else $error("registers moved");
   chk_hold_edge: assert property (select_n_i [*7] |-> $stable(out_on_rise_o))
      else $error("edge setting moved");
   chk_quiet_out: assert property ((!select_n_i && $stable(shift_clk_i)) [*6]
      |-> $stable(serial_out_o)) else $error("serial out moved");
   chk_rise_mode: assert property (out_on_rise_o && !select_n_i && $fell(shift_clk_i)
      |=> $stable(serial_out_o) [*5]) else $error("moved after fall");
   chk_fall_mode: assert property (!out_on_rise_o && !select_n_i && $rose(shift_clk_i)
      |=> $stable(serial_out_o) [*5]) else $error("moved after rise");
   chk_sel_release: assert property ($rose(select_n_i) |-> ##[1:5] serial_out_o)
      else $error("serial out not released");
endmodule
bind qdl_serial_port qdl_serial_port_monitor qdl_serial_port_monitor_inst (.ref_clk_i,
   .reset_i, .shift_clk_i, .select_n_i, .load_all_strobe_n_i, .serial_out_o,
   .converter_value_o, .out_on_rise_o);
`default_nettype wire

// >>> test/testbench.sv
/* testbench: drives the serial load port through the master model.
   Assumes the master model keeps outputs idle until called. */
`timescale 1ns/100ps
`default_nettype none
module testbench
   import qdl_pkg::*;
;
   logic                                  ref_clk_i = 1'b0;
   logic                                  reset_i   = 1'b1;
   logic                                  strobe_n  = 1'b1;
   wire logic                             sclk, sel_n, sin, sout, rise;
   wire logic [CHANNELS-1:0][VALUE_BITS-1:0] conv_o;
   int                                    error_cnt = 0;
   int                                    tests_run = 0;
   logic [VALUE_BITS-1:0]                 inp [CHANNELS] = '{default: VALUE_RESET};
   logic [VALUE_BITS-1:0]                 conv [CHANNELS] = '{default: VALUE_RESET};
   logic [FRAME_BITS-1:0]                 last = SHIFT_RESET;
   logic                                  edge_m = EDGE_RESET;
   always #2 ref_clk_i = ~ref_clk_i;
   qdl_serial_port qdl_serial_port_inst (.ref_clk_i, .reset_i, .shift_clk_i(sclk),
      .select_n_i(sel_n), .serial_in_i(sin), .load_all_strobe_n_i(strobe_n),
      .serial_out_o(sout), .converter_value_o(conv_o), .out_on_rise_o(rise));
   qdl_link_master qdl_link_master_inst (.ref_clk_i, .serial_out_i(sout),
      .shift_clk_o(sclk), .select_n_o(sel_n), .serial_in_o(sin));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic regs_ok();
      check(64'(conv_o), 64'({conv[3], conv[2], conv[1], conv[0]}));
      check(64'(rise), 64'(edge_m));
      check(64'(sout), 64'(SOUT_IDLE));
   endtask
   // one frame, then the reference model of the commit
   task automatic send(input logic [1:0] a, input logic [1:0] c, input logic [11:0] v,
                       input int gap);
      logic [FRAME_BITS-1:0] echo;
      qdl_link_master_inst.xfer({a, c, v}, gap, echo);
      check(64'(echo), 64'(last));
      last = {a, c, v};
      case (c)
         CMD_LOAD_INPUT: inp[a] = v;
         CMD_LOAD_BOTH: begin
            inp[a] = v;
            conv[a] = v;
         end
         CMD_UPDATE_ALL: conv = inp;
         default: edge_m = a[1];
      endcase
      if (!strobe_n) conv = inp;
      repeat (6) @(posedge ref_clk_i);
      // look off the edge, and leave the next caller just after it
      #1;
      regs_ok();
   endtask
   task automatic t_buffered();
      send(2'h0, CMD_LOAD_INPUT, 12'h123, 0);
      send(2'h1, CMD_LOAD_INPUT, 12'hFFF, 0);
      send(2'h3, CMD_UPDATE_ALL, 12'h000, 0);
      $display("buffered load done");
   endtask
   task automatic t_direct();
      for (int i = 0; i < CHANNELS; i++) send(i[1:0], CMD_LOAD_BOTH, 12'(12'hA50 + i), i);
      $display("direct load done");
   endtask
   task automatic t_strobe();
      send(2'h2, CMD_LOAD_INPUT, 12'h5A5, 0);
      @(posedge ref_clk_i);
      #1 strobe_n = 1'b0;
      conv = inp;
      repeat (8) @(posedge ref_clk_i);
      #1 regs_ok();
      send(2'h3, CMD_LOAD_INPUT, 12'hC3C, 0);
      // send already returns just after an edge
      strobe_n = 1'b1;
      $display("strobe done");
   endtask
   task automatic t_edges();
      send(2'h2, CMD_OUT_EDGE, 12'hFFF, 0);
      send(2'h1, CMD_LOAD_BOTH, 12'h0F0, 1);
      send(2'h0, CMD_OUT_EDGE, 12'h000, 0);
      send(2'h2, CMD_LOAD_BOTH, 12'h00F, 0);
      $display("edge settings done");
   endtask
   task automatic t_ignore();
      qdl_link_master_inst.stray(4);
      regs_ok();
      send(2'h0, CMD_LOAD_BOTH, 12'h777, 0);
      $display("ignored clocks done");
   endtask
   initial begin
      repeat (12) @(posedge ref_clk_i);
      #1 reset_i = 1'b0;
      regs_ok();
      repeat (4) @(posedge ref_clk_i);
      #1;
      t_buffered();
      t_direct();
      t_strobe();
      t_edges();
      t_ignore();
      final_report();
   end
   // hang guard well above the run length
   initial begin
      repeat (90000) @(posedge ref_clk_i);
      error_cnt++;
      final_report();
   end
endmodule
`default_nettype wire
